// ===== logic/port_e_pad_ctrl.sv
/*
 * Port E pin function mux with direction, function select, pull-up and
 * reduced-drive registers.
 * Assumes mode straps are stable pins, bus signals come from the core clock.
 */
module port_e_pad_ctrl
	import port_e_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [2:0] mode_pins,
	input  wire logic       port_e_emulation,
	input  wire logic       bus_clock_stretch,
	input  wire logic [15:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [7:0] rdata,
	output logic            reg_hit,
	input  wire logic [7:0] gpio_out,
	input  wire logic [7:0] pin_in,
	output logic      [7:0] pin_level,
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe,
	output logic      [7:0] pin_pullup,
	input  wire logic       data_bus_gate,
	input  wire logic       bus_clock,
	input  wire logic       bus_rd_wr,
	input  wire logic       byte_strobe,
	input  wire logic       queue_status_hi,
	input  wire logic       queue_status_lo,
	input  wire logic       clockgen_test,
	input  wire logic       trim_reference,
	input  wire logic       tag_enable,
	output logic            low_byte_tag,
	output logic      [7:0] port_pullup_en,
	output logic      [7:0] port_reduced_drive,
	output logic            bus_clock_is_input
);

	// ------------------------------------------------------------------
	// Synchronisers and mode capture
	// ------------------------------------------------------------------
	logic [7:0] pin_s1_q;
	logic [7:0] pin_s2_q;
	logic [2:0] mode_s1_q;
	logic [2:0] mode_s2_q;
	logic [2:0] mode_q;
	logic       init_q;
	logic       init_d;
	logic       clk_prev_q;
	logic       tag_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q  <= 8'h00;
			pin_s2_q  <= 8'h00;
			mode_s1_q <= 3'h0;
			mode_s2_q <= 3'h0;
		end else begin
			pin_s1_q  <= pin_in;
			pin_s2_q  <= pin_s1_q;
			mode_s1_q <= mode_pins;
			mode_s2_q <= mode_s1_q;
		end
	end

	// The straps settle through the synchroniser, then are latched once.
	logic [1:0] boot_cnt_q;
	assign init_d = (boot_cnt_q == 2'h2);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			boot_cnt_q <= 2'h0;
			mode_q     <= MODE_NORM_SC;
			init_q     <= 1'b0;
		end else begin
			if (boot_cnt_q != 2'h3) begin
				boot_cnt_q <= boot_cnt_q + 2'h1;
			end
			if (init_d) begin
				mode_q <= mode_s2_q;
			end
			init_q <= init_d;
		end
	end

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	op_mode_t mode;
	wire      special   = ~mode_q[2];
	assign mode = op_mode_t'(mode_q);
	wire      periph    = (mode == MODE_PERIPH);
	wire      single    = (mode == MODE_SPEC_SC) || (mode == MODE_NORM_SC);
	wire      expanded  = ~single & ~periph;
	wire      norm_narrow = (mode == MODE_NORM_EXP_N);

	logic [7:0] fs_reset;
	always_comb begin
		case (mode)
			MODE_NORM_SC:    fs_reset = RST_FS_NORM_SC;
			MODE_SPEC_SC:    fs_reset = RST_FS_SPEC_SC;
			MODE_PERIPH:     fs_reset = RST_FS_PERIPH;
			MODE_NORM_EXP_N,
			MODE_NORM_EXP_W: fs_reset = RST_FS_NORM_EXP;
			default:         fs_reset = RST_FS_SPEC_EXP;
		endcase
	end

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	wire dir_mapped = ~periph & ~(expanded & port_e_emulation);
	wire sel_dir   = dir_mapped && (addr == OFF_DIRECTION);
	wire sel_fs    = ~periph && (addr == OFF_FUNCTION_SEL);
	wire sel_pu    = ~periph && (addr == OFF_PULLUP);
	wire sel_drv   = ~periph && (addr == OFF_DRIVE);
	wire any_sel   = sel_dir | sel_fs | sel_pu | sel_drv;

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0] dir_q;
	logic [7:0] pu_q;
	logic [7:0] fs;
	logic [7:0] drv;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dir_q <= RST_DIRECTION;
			pu_q  <= RST_PULLUP;
		end else begin
			if (wr_stb && sel_dir) begin
				dir_q <= wdata & DIR_WRITE_MASK;
			end
			if (wr_stb && sel_pu) begin
				pu_q <= wdata & PU_WRITE_MASK;
			end
		end
	end

	// ------------------------------------------------------------------
	// Function select
	// ------------------------------------------------------------------
	// The clock test bit never changes in normal modes. The bus clock
	// disable bit is held apart below because its policy follows the mode.
	logic [7:0] fs_raw;
	logic [7:0] fs_wdata;
	logic [7:0] fs_keep;
	wire        fs_hit = wr_stb && sel_fs;
	assign fs_keep  = special ? 8'h00 : (8'h01 << FS_CLKGEN_TEST);
	assign fs_wdata = (wdata & ~fs_keep) | (fs_raw & fs_keep);

	guarded_reg #(
		.ONCE_MASK  (FS_ONCE_MASK),
		.FREE_MASK  (FS_FREE_MASK),
		.NEVER_MASK (8'h00)
	) u_fs (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.load     (init_q),
		.load_val (fs_reset),
		.special  (special),
		.wr       (fs_hit),
		.wdata    (fs_wdata),
		.value    (fs_raw)
	);

	// Bus clock disable: one write in normal single-chip, any write in
	// special single-chip, fixed in every other mode. A guarded byte cannot
	// switch its policy by mode, so this bit has a flop of its own.
	// Every write to the byte spends the single chance, even one that
	// leaves this bit alone.
	logic clk_dis_q;
	logic clk_dis_used_q;
	wire  clk_dis_wr = fs_hit
		&& ((mode == MODE_SPEC_SC)
		|| ((mode == MODE_NORM_SC) && !clk_dis_used_q));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clk_dis_q      <= 1'b0;
			clk_dis_used_q <= 1'b0;
		end else if (init_q) begin
			clk_dis_q      <= fs_reset[FS_BUS_CLK_DIS];
			clk_dis_used_q <= 1'b0;
		end else begin
			if (clk_dis_wr) begin
				clk_dis_q <= wdata[FS_BUS_CLK_DIS];
			end
			if (fs_hit) begin
				clk_dis_used_q <= 1'b1;
			end
		end
	end

	assign fs = {fs_raw[7:5], clk_dis_q, fs_raw[3:0]};

	guarded_reg #(
		.ONCE_MASK  (DRIVE_WRITE_MASK),
		.FREE_MASK  (8'h00),
		.NEVER_MASK (8'h00)
	) u_drv (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.load     (1'b0),
		.load_val (RST_DRIVE),
		.special  (special),
		.wr       (wr_stb && sel_drv),
		.wdata    (wdata),
		.value    (drv)
	);

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	logic [7:0] rd_mux;
	assign rd_mux = sel_dir ? dir_q :
	                sel_fs  ? fs    :
	                sel_pu  ? pu_q  :
	                sel_drv ? drv   : 8'h00;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata   <= 8'h00;
			reg_hit <= 1'b0;
		end else begin
			rdata   <= rd_stb ? rd_mux : 8'h00;
			reg_hit <= rd_stb & any_sel;
		end
	end

	// ------------------------------------------------------------------
	// Pin function mux
	// ------------------------------------------------------------------
	wire gate_dis = fs[FS_BUS_GATE_DIS];
	wire trim_en  = fs[FS_TRIM_REF];
	wire queue_on = fs[FS_QUEUE_OUT] & expanded;
	wire test_on  = fs[FS_CLKGEN_TEST] & ~single
		& ~(mode == MODE_NORM_EXP_N || mode == MODE_NORM_EXP_W);
	wire clk_on   = ~fs[FS_BUS_CLK_DIS]
		& ~periph & ~(single & bus_clock_stretch);
	wire strobe_on = fs[FS_BYTE_STROBE] & ~single & ~norm_narrow;
	wire rw_on    = fs[FS_DIR_PIN] & ~single;
	wire gate_on  = expanded & ~gate_dis;
	wire trim_on  = trim_en & (single | periph | gate_dis);

	// Each pin takes at most one alternate role; the order of the tests
	// below is the priority between roles that share a pin.
	logic [7:0] alt_sel;
	logic [7:0] alt_val;
	always_comb begin
		alt_sel = 8'h00;
		alt_val = 8'h00;
		if (gate_on) begin
			alt_sel[7] = 1'b1;
			alt_val[7] = fs[FS_INV_CLK_SEL] ? ~bus_clock : data_bus_gate;
		end else if (trim_on) begin
			alt_sel[7] = 1'b1;
			alt_val[7] = trim_reference;
		end
		if (queue_on) begin
			alt_sel[6:5] = 2'h3;
			alt_val[6:5] = {queue_status_hi, queue_status_lo};
		end else if (test_on) begin
			alt_sel[6] = 1'b1;
			alt_val[6] = clockgen_test;
		end
		if (clk_on) begin
			alt_sel[4] = 1'b1;
			alt_val[4] = bus_clock;
		end
		if (strobe_on) begin
			alt_sel[3] = 1'b1;
			alt_val[3] = byte_strobe;
		end else if (norm_narrow) begin
			alt_sel[3] = 1'b1;
			alt_val[3] = 1'b1;
		end
		if (rw_on) begin
			alt_sel[2] = 1'b1;
			alt_val[2] = bus_rd_wr;
		end
	end

	// Bits 1:0 of the direction register are hard zero, so those pins never drive.
	assign pin_oe    = alt_sel | (dir_q & ~alt_sel);
	assign pin_out   = (alt_val & alt_sel) | (gpio_out & ~alt_sel);
	assign pin_level = pin_s2_q;
	assign pin_pullup = pu_q[PU_PORT_E] ? (PU_E_PIN_MASK & ~pin_oe & 8'h8f) : 8'h00;
	assign bus_clock_is_input = periph;

	// Pull-ups for ports A and B drop out while those ports carry the bus.
	always_comb begin
		port_pullup_en = pu_q;
		if (~single) begin
			port_pullup_en[PU_PORT_A] = 1'b0;
			port_pullup_en[PU_PORT_B] = 1'b0;
		end
	end
	assign port_reduced_drive = drv;

	// Tagging: a low on pin 3 at the falling edge of the bus clock.
	wire tag_mode = ~mode_q[2] & expanded & fs[FS_BYTE_STROBE] & tag_enable;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clk_prev_q <= 1'b0;
			tag_q      <= 1'b0;
		end else begin
			clk_prev_q <= bus_clock;
			tag_q      <= tag_mode & clk_prev_q & ~bus_clock & ~pin_s2_q[3];
		end
	end
	assign low_byte_tag = tag_q;

endmodule : port_e_pad_ctrl

// ===== shared/port_e_pkg.sv
/*
 * Constants for the port E function and pad control block: register offsets,
 * reset values per mode, field positions and the operating mode encoding.
 * Assumes an 8-bit register port with byte-wide offsets as printed.
 */
package port_e_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [15:0] OFF_DIRECTION    = 16'h0009;
	localparam logic [15:0] OFF_FUNCTION_SEL = 16'h000a;
	localparam logic [15:0] OFF_PULLUP       = 16'h000c;
	localparam logic [15:0] OFF_DRIVE        = 16'h000d;

	// ------------------------------------------------------------------
	// Function select field positions
	// ------------------------------------------------------------------
	localparam int FS_BUS_GATE_DIS  = 7;
	localparam int FS_CLKGEN_TEST   = 6;
	localparam int FS_QUEUE_OUT     = 5;
	localparam int FS_BUS_CLK_DIS   = 4;
	localparam int FS_BYTE_STROBE   = 3;
	localparam int FS_DIR_PIN       = 2;
	localparam int FS_TRIM_REF      = 1;
	localparam int FS_INV_CLK_SEL   = 0;

	// ------------------------------------------------------------------
	// Pull-up field positions and masks
	// ------------------------------------------------------------------
	localparam int PU_PORT_E        = 4;
	localparam int PU_PORT_B        = 1;
	localparam int PU_PORT_A        = 0;
	localparam logic [7:0] PU_WRITE_MASK   = 8'hf3;
	localparam logic [7:0] PU_E_PIN_MASK   = 8'h8f;
	localparam logic [7:0] DIR_WRITE_MASK  = 8'hfc;
	localparam logic [7:0] DRIVE_WRITE_MASK = 8'hff;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_DIRECTION  = 8'h00;
	localparam logic [7:0] RST_PULLUP     = 8'h10;
	localparam logic [7:0] RST_DRIVE      = 8'h00;
	localparam logic [7:0] RST_FS_NORM_EXP = 8'h00;
	localparam logic [7:0] RST_FS_SPEC_EXP = 8'h2c;
	localparam logic [7:0] RST_FS_PERIPH   = 8'hd0;
	localparam logic [7:0] RST_FS_NORM_SC  = 8'h90;
	localparam logic [7:0] RST_FS_SPEC_SC  = 8'h2e;
	// Per-bit write policy masks of the function select register.
	localparam logic [7:0] FS_ONCE_MASK    = 8'ha5 | 8'h0a;
	localparam logic [7:0] FS_FREE_MASK    = 8'h02;

	// ------------------------------------------------------------------
	// Operating modes
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_SPEC_SC    = 3'h0,
		MODE_SPEC_EXP_N = 3'h1,
		MODE_PERIPH     = 3'h2,
		MODE_SPEC_EXP_W = 3'h3,
		MODE_NORM_SC    = 3'h4,
		MODE_NORM_EXP_N = 3'h5,
		MODE_NORM_EXP_W = 3'h7,
		MODE_RESERVED   = 3'h6
	} op_mode_t;

endpackage : port_e_pkg

// ===== logic/guarded_reg.sv
/*
 * One byte of storage with write-once or write-after-first protection.
 * Assumes write strobe and data come from logic on the same clock.
 */
module guarded_reg
	import port_e_pkg::*;
#(
	parameter logic [7:0] ONCE_MASK = 8'h00,
	parameter logic [7:0] FREE_MASK = 8'h00,
	parameter logic [7:0] NEVER_MASK = 8'h00
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [7:0] load_val,
	input  wire logic       special,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] value
);

	logic [7:0] value_q;
	logic       touched_q;
	logic [7:0] en;

	// Outside FREE_MASK, normal modes take the first write to ONCE_MASK bits only; special modes skip it.
	assign en = FREE_MASK
		| (special ? (touched_q ? ~NEVER_MASK : 8'h00) : (touched_q ? 8'h00 : ONCE_MASK));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			value_q   <= 8'h00;
			touched_q <= 1'b0;
		end else if (load) begin
			value_q   <= load_val;
			touched_q <= 1'b0;
		end else if (wr) begin
			value_q   <= (value_q & ~en) | (wdata & en);
			touched_q <= 1'b1;
		end
	end

	assign value = value_q;

endmodule : guarded_reg

// ===== bench/port_e_pad_sva.sv
/* Checker for the port E pad control block.
 * Assumes one clock domain and the top module's ports only. */
module port_e_pad_sva
	import port_e_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [15:0] addr,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [7:0]  rdata,
	input wire logic        reg_hit,
	input wire logic [7:0]  pin_in,
	input wire logic [7:0]  pin_level,
	input wire logic [7:0]  pin_oe,
	input wire logic [7:0]  pin_pullup,
	input wire logic        tag_enable,
	input wire logic        low_byte_tag,
	input wire logic [7:0]  port_reduced_drive,
	input wire logic        bus_clock_is_input
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// Properties
	// ----
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence rd_unmapped;
		rd_stb && (addr > OFF_DRIVE);
	endsequence
	sequence rd_idle;
		!rd_stb;
	endsequence
	unmapped_read_a: assert property (rd_unmapped |=> rdata == 8'h00 && !reg_hit)
		else $error("unmapped read answered");
	idle_rdata_a: assert property (rd_idle |=> rdata == 8'h00)
		else $error("read data without a read");
	hit_cause_a: assert property (reg_hit |-> $past(rd_stb))
		else $error("hit without a read");
	irq_pins_a: assert property (pin_oe[1:0] == 2'b00)
		else $error("interrupt pin driven");
	sync_level_a: assert property ($stable(pin_in[0])[*4] |-> pin_level[0] == pin_in[0])
		else $error("pin level not followed");
	pullup_inputs_a: assert property ((pin_pullup & (pin_oe | ~PU_E_PIN_MASK)) == 8'h00)
		else $error("pull-up on output or wrong pin");
	clk_input_a: assert property (bus_clock_is_input |-> !pin_oe[4])
		else $error("bus clock pin driven as input");
	tag_pulse_a: assert property (low_byte_tag |-> $past(tag_enable, 2) ##1 !low_byte_tag)
		else $error("bad tag pulse");
	drive_hold_a: assert property (!wr_stb |=> $stable(port_reduced_drive))
		else $error("drive changed without write");
endmodule : port_e_pad_sva

bind port_e_pad_ctrl port_e_pad_sva i_sva (
	.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rdata(rdata), .reg_hit(reg_hit), .pin_in(pin_in), .pin_level(pin_level),
	.pin_oe(pin_oe), .pin_pullup(pin_pullup), .tag_enable(tag_enable),
	.low_byte_tag(low_byte_tag), .port_reduced_drive(port_reduced_drive),
	.bus_clock_is_input(bus_clock_is_input)
);

// ===== bench/ext_bus_model.sv
/* Pads and external bus devices seen from port E.
 * Assumes pad enables come from the block and external drive from the bench. */
module ext_bus_model (
	input  wire logic       mclk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pullup,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// Pad resolution
	// ----
	logic [7:0] last_q = 8'h00;
	always_ff @(posedge mclk) begin
		last_q <= pin_in;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (ext_en[i]) pin_in[i] = ext_val[i];
			else if (pin_oe[i]) pin_in[i] = pin_out[i];
			else if (pin_pullup[i]) pin_in[i] = 1'b1;
			else pin_in[i] = ~last_q[i];
		end
	end
endmodule : ext_bus_model

// ===== bench/tb_top.sv
/* Self-checking bench for the port E pad control block.
 * Assumes the package constants and the pad model beside it. */
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
	import port_e_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// Signals
	// ----
	logic        mclk, rst_n, wr_stb, rd_stb, reg_hit, hid, seen, low_byte_tag;
	logic        port_e_emulation, bus_clock_stretch, bus_clock, tag_enable;
	logic        data_bus_gate, bus_rd_wr, byte_strobe, queue_status_hi;
	logic        queue_status_lo, clockgen_test, trim_reference, bus_clock_is_input;
	logic [2:0]  mode_pins;
	logic [15:0] addr;
	logic [7:0]  wdata, rdata, pin_in, pin_level, pin_out, pin_oe, pin_pullup;
	logic [7:0]  port_pullup_en, port_reduced_drive, ext_en, ext_val, gpio_out;
	logic [7:0]  cnt = 8'h00;
	int          err_total = 0;
	int          checks_done = 0;
	op_mode_t    m_tab[7] = '{MODE_NORM_SC, MODE_NORM_EXP_W, MODE_NORM_EXP_N,
		MODE_SPEC_EXP_W, MODE_SPEC_SC, MODE_SPEC_EXP_N, MODE_PERIPH};
	logic [7:0]  fs_tab[7] = '{8'h90, 8'h00, 8'h00, 8'h2c, 8'h2e, 8'h2c, 8'h00};
	logic [7:0]  oe_tab[7] = '{8'h00, 8'h90, 8'h98, 8'hfc, 8'h90, 8'hfc, 8'h40};
	assign gpio_out = cnt;
	assign {data_bus_gate, bus_rd_wr, byte_strobe, queue_status_hi} = cnt[6:3];
	assign {queue_status_lo, clockgen_test, trim_reference} = cnt[2:0];
	always @(posedge mclk) cnt <= cnt + 8'h01;
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	port_e_pad_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .mode_pins(mode_pins),
		.port_e_emulation(port_e_emulation), .bus_clock_stretch(bus_clock_stretch),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.reg_hit(reg_hit), .gpio_out(gpio_out), .pin_in(pin_in), .pin_level(pin_level),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.data_bus_gate(data_bus_gate), .bus_clock(bus_clock), .bus_rd_wr(bus_rd_wr),
		.byte_strobe(byte_strobe), .queue_status_hi(queue_status_hi),
		.queue_status_lo(queue_status_lo), .clockgen_test(clockgen_test),
		.trim_reference(trim_reference), .tag_enable(tag_enable),
		.low_byte_tag(low_byte_tag), .port_pullup_en(port_pullup_en),
		.port_reduced_drive(port_reduced_drive), .bus_clock_is_input(bus_clock_is_input));
	ext_bus_model i_ext (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
	// ----
	// Tasks
	// ----
	task automatic end_sim();
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic rst(input op_mode_t m, input int n);
		@(posedge mclk);
		rst_n     <= 1'b0;
		mode_pins <= m;
		repeat (n) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
	endtask : rst
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr_stb <= 1'b1;
		addr   <= a;
		wdata  <= d;
		@(posedge mclk);
		wr_stb <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
		@(posedge mclk);
		rd_stb <= 1'b1;
		addr   <= a;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
		`CHK("reg_hit", h, reg_hit)
	endtask : rd
	// ----
	// Tests
	// ----
	initial begin
		rst_n = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0; addr = 16'h0000; wdata = 8'h00;
		mode_pins = MODE_NORM_EXP_W; port_e_emulation = 1'b0; bus_clock_stretch = 1'b0;
		bus_clock = 1'b0; tag_enable = 1'b0; ext_en = 8'h00; ext_val = 8'h00;
		rst(MODE_NORM_EXP_W, 20);
		foreach (m_tab[i]) begin
			rst(m_tab[i], 3);
			hid = (m_tab[i] == MODE_PERIPH);
			`CHK("pin_oe", oe_tab[i], pin_oe)
			if (m_tab[i] == MODE_NORM_EXP_N) `CHK("strobe", 1'b1, pin_out[3])
			if (hid) `CHK("test", clockgen_test, pin_out[6])
			`CHK("clk_in", hid, bus_clock_is_input)
			rd(OFF_FUNCTION_SEL, fs_tab[i], !hid);
			rd(OFF_DIRECTION, 8'h00, !hid);
			rd(OFF_PULLUP, hid ? 8'h00 : 8'h10, !hid);
			rd(OFF_DRIVE, 8'h00, !hid);
		end
		rst(MODE_NORM_EXP_W, 3);
		@(posedge mclk);
		port_e_emulation <= 1'b1;
		rd(OFF_DIRECTION, 8'h00, 1'b0);
		@(posedge mclk);
		port_e_emulation <= 1'b0;
		wr(OFF_FUNCTION_SEL, 8'hff);
		rd(OFF_FUNCTION_SEL, 8'haf, 1'b1);
		`CHK("trim", trim_reference, pin_out[7])
		wr(OFF_FUNCTION_SEL, 8'h00);
		rd(OFF_FUNCTION_SEL, 8'had, 1'b1);
		wr(OFF_DIRECTION, 8'hff);
		rd(OFF_DIRECTION, 8'hfc, 1'b1);
		`CHK("gpio", gpio_out[7], pin_out[7])
		wr(OFF_DIRECTION, 8'h00);
		wr(OFF_PULLUP, 8'hff);
		rd(OFF_PULLUP, 8'hf3, 1'b1);
		`CHK("pin_oe", 8'h7c, pin_oe)
		`CHK("pullup", 8'h83, pin_pullup)
		`CHK("ab_pullup", 2'b00, port_pullup_en[1:0])
		wr(OFF_DRIVE, 8'h55);
		wr(OFF_DRIVE, 8'haa);
		rd(OFF_DRIVE, 8'h55, 1'b1);
		rd(16'h000e, 8'h00, 1'b0);
		rst(MODE_SPEC_EXP_W, 3);
		`CHK("gate", data_bus_gate, pin_out[7])
		wr(OFF_FUNCTION_SEL, 8'h02);
		rd(OFF_FUNCTION_SEL, 8'h2e, 1'b1);
		wr(OFF_FUNCTION_SEL, 8'hff);
		rd(OFF_FUNCTION_SEL, 8'hef, 1'b1);
		`CHK("queue", {queue_status_hi, queue_status_lo}, pin_out[6:5])
		`CHK("strobe", byte_strobe, pin_out[3])
		`CHK("rw", bus_rd_wr, pin_out[2])
		wr(OFF_FUNCTION_SEL, 8'h01);
		rd(OFF_FUNCTION_SEL, 8'h01, 1'b1);
		`CHK("inv_clk", ~bus_clock, pin_out[7])
		`CHK("pin_oe", 8'h90, pin_oe)
		`CHK("pullup", 8'h0f, pin_pullup)
		wr(OFF_DRIVE, 8'h11);
		wr(OFF_DRIVE, 8'h22);
		rd(OFF_DRIVE, 8'h22, 1'b1);
		`CHK("drive", 8'h22, port_reduced_drive)
		wr(OFF_FUNCTION_SEL, 8'h08);
		@(posedge mclk);
		tag_enable <= 1'b1;
		ext_en     <= 8'h08;
		bus_clock  <= 1'b1;
		repeat (3) @(posedge mclk);
		bus_clock <= 1'b0;
		seen = 1'b0;
		repeat (8) begin
			@(negedge mclk);
			if (low_byte_tag === 1'b1) seen = 1'b1;
		end
		`CHK("tag", 1'b1, seen)
		@(posedge mclk);
		ext_en     <= 8'h00;
		tag_enable <= 1'b0;
		rst(MODE_NORM_SC, 3);
		wr(OFF_FUNCTION_SEL, 8'h00);
		rd(OFF_FUNCTION_SEL, 8'h00, 1'b1);
		`CHK("pin_oe", 8'h10, pin_oe)
		@(posedge mclk);
		bus_clock_stretch <= 1'b1;
		@(posedge mclk);
		#1;
		`CHK("pin_oe", 8'h00, pin_oe)
		@(posedge mclk);
		bus_clock_stretch <= 1'b0;
		wr(OFF_FUNCTION_SEL, 8'h90);
		rd(OFF_FUNCTION_SEL, 8'h00, 1'b1);
		wr(OFF_PULLUP, 8'hff);
		`CHK("pullup_en", 8'hf3, port_pullup_en)
		rst(MODE_SPEC_SC, 3);
		wr(OFF_FUNCTION_SEL, 8'h10);
		rd(OFF_FUNCTION_SEL, 8'h3c, 1'b1);
		end_sim();
	end
	initial begin
		repeat (4000) @(posedge mclk);
		err_total++;
		end_sim();
	end
endmodule : tb_top
